// >>> verification/nvsh_dev_model.sv
/*
  behavioural model of the shadow-backed 8k x 8 static ram on the host pins.
  assumes host-driven strobes and a resolved data bus fed back on bus_in.
*/
`timescale 1ns/1ps
`default_nettype none
module nvsh_dev_model
  import nvsh_pkg::*;
#(
  parameter int save_ns = 400,
  parameter int restore_ns = 400,
  parameter int powerup_ns = 400
)
(
  input wire logic chip_select_n,
  input wire logic write_strobe_n,
  input wire logic output_drive_n,
  input wire logic [12:0] byte_select_lines,
  input wire logic [7:0] bus_in,
  input wire logic supply_ok,
  input wire logic store_cap_ok,
  output logic [7:0] bus_out,
  output logic bus_drive
);
  logic [7:0] ram [0:8191];
  logic [7:0] shadow [0:8191];
  logic busy = 1'b0;
  logic pend = 1'b1;
  logic in_pu = 1'b0;
  logic wr_act = 1'b0;
  logic rd_act = 1'b0;
  logic [12:0] act_addr = 13'h0000;
  int step = 0;
  int busy_len = 0;
  logic reading;
  logic rd_late;
  logic [7:0] rd_data;
  localparam logic [12:0] seq_tab [0:4] = '{seq_addr_0, seq_addr_1, seq_addr_2, seq_addr_3, seq_addr_4};

  // drive turns off at once but on only after the access delay
  assign reading = !chip_select_n && !output_drive_n && write_strobe_n && !busy;
  assign #20 rd_late = reading;
  assign #20 rd_data = ram[byte_select_lines];
  assign bus_drive = reading && rd_late;
  // released lines show the inverse so a stale sample never passes
  assign bus_out = bus_drive ? rd_data : ~rd_data;

  // shadow holds a known pattern, ram all zeros until the first restore
  initial
  begin
    for (int i = 0; i < 8192; i++)
    begin
      shadow[i] = 8'(i) ^ 8'h5a;
      ram[i] = 8'h00;
    end
  end

  task automatic restore(input int ns, input logic pu);
    step = 0;
    for (int i = 0; i < 8192; i++)
      ram[i] = 8'h00;
    for (int i = 0; i < 8192; i++)
      ram[i] = shadow[i];
    busy_len = ns;
    in_pu = pu;
    busy = 1'b1;
  endtask

  // six reads in exact order; anything else restarts the count
  task automatic seq_step(input logic [12:0] a);
    if (step < 5 && a == seq_tab[step])
      step++;
    else if (step == 5 && a == seq_save_addr && store_cap_ok)
    begin
      step = 0;
      for (int i = 0; i < 8192; i++)
        shadow[i] = 8'hff;
      for (int i = 0; i < 8192; i++)
        shadow[i] = ram[i];
      busy_len = save_ns;
      in_pu = 1'b0;
      busy = 1'b1;
    end
    else if (step == 5 && a == seq_restore_addr)
      restore(restore_ns, 1'b0);
    else
      step = (a == seq_tab[0]) ? 1 : 0;
  endtask

  // accesses open and close on strobe edges; nothing is seen while busy
  always @(chip_select_n or write_strobe_n)
  begin
    if (busy)
    begin
      wr_act = 1'b0;
      rd_act = 1'b0;
    end
    else if (!chip_select_n && !write_strobe_n)
    begin
      if (!wr_act)
        act_addr = byte_select_lines;
      wr_act = 1'b1;
      rd_act = 1'b0;
    end
    else if (wr_act)
    begin
      if (store_cap_ok && byte_select_lines == act_addr)
        ram[act_addr] = bus_in;
      wr_act = 1'b0;
      step = 0;
    end
    else if (!chip_select_n)
    begin
      rd_act = 1'b1;
      act_addr = byte_select_lines;
    end
    else if (rd_act)
    begin
      rd_act = 1'b0;
      seq_step(act_addr);
    end
  end

  // low supply arms a restore that runs when the supply returns
  always @(supply_ok)
  begin
    if (!supply_ok)
      pend = 1'b1;
    else if (pend)
    begin
      pend = 1'b0;
      restore(powerup_ns, 1'b1);
    end
  end

  // a write still held as the power-up restore ends spoils that byte
  always @(posedge busy)
  begin
    #(busy_len);
    if (in_pu && !chip_select_n && !write_strobe_n)
      ram[byte_select_lines] = 8'hxx;
    busy = 1'b0;
  end
endmodule
`default_nettype wire

// >>> verification/testbench.sv
/*
  self-checking bench for nvsh_host against the behavioural device model.
  assumes nvsh_pkg, nvsh_host and nvsh_dev_model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import nvsh_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic cmd_valid = 1'b0;
  logic [7:0] cmd_op = 8'h00;
  logic [12:0] cmd_addr = 13'h0000;
  logic [7:0] cmd_wdata = 8'h00;
  logic supply_ok = 1'b0;
  logic store_cap_ok = 1'b1;
  logic cmd_ready, rsp_valid, save_refused, host_oe, cs_n, we_n, od_n, dev_drive;
  logic [7:0] rsp_rdata, host_out, dev_out, q;
  logic [12:0] addr_pins;
  wire [7:0] dq;
  int miscompares = 0;
  int total_checks = 0;
  logic rec = 1'b0;
  logic refused;
  logic [13:0] seq_q [$];

  always #12.5 clock = ~clock;
  // both sides driving at once reads as unknown
  assign dq = (host_oe && dev_drive) ? 8'hxx : (host_oe ? host_out : dev_out);

  nvsh_host #(.save_cycles(20), .restore_cycles(20), .powerup_cycles(20)) dut_u (
    .clock(clock), .rst(rst), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .save_refused(save_refused), .supply_ok(supply_ok), .store_cap_ok(store_cap_ok),
    .byte_select_lines(addr_pins), .shared_data_lines_out(host_out), .shared_data_lines_oe(host_oe),
    .shared_data_lines_in(dq), .chip_select_n(cs_n), .write_strobe_n(we_n), .output_drive_n(od_n));

  nvsh_dev_model dev_u (
    .chip_select_n(cs_n), .write_strobe_n(we_n), .output_drive_n(od_n), .byte_select_lines(addr_pins),
    .bus_in(dq), .supply_ok(supply_ok), .store_cap_ok(store_cap_ok), .bus_out(dev_out),
    .bus_drive(dev_drive));

  // select falls are logged so the step order on the pins can be judged
  always @(negedge cs_n)
    if (rec)
      seq_q.push_back({we_n, addr_pins});

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // bounded wait for the answer pulse of either kind; a refusal pulses on the take edge itself
  task automatic wait_rsp();
    int n;
    n = 0;
    #1;
    while (rsp_valid !== 1'b1 && save_refused !== 1'b1 && n < 4000)
    begin
      @(posedge clock);
      #1;
      n++;
    end
    q = rsp_rdata;
    refused = save_refused;
    if (n >= 4000)
      miscompares++;
  endtask

  task automatic do_cmd(input logic [7:0] op, input logic [12:0] a, input logic [7:0] d);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 4000)
    begin
      @(posedge clock);
      #1;
      n++;
    end
    @(posedge clock);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_addr <= a;
    cmd_wdata <= d;
    @(posedge clock);
    cmd_valid <= 1'b0;
    wait_rsp();
  endtask

  task automatic s_powerup();
    supply_ok <= 1'b1;
    wait_rsp();
    do_cmd(cmd_read, 13'h0123, 8'h00);
    check(q, 8'h79);
  endtask

  // extremes and an alias pair of the address space, back to back
  task automatic s_rw();
    logic [12:0] tab [5] = '{13'h0000, 13'h1fff, 13'h1000, 13'h0aaa, 13'h1555};
    foreach (tab[i])
      do_cmd(cmd_write, tab[i], 8'h11 * 8'(i + 1));
    foreach (tab[i])
    begin
      do_cmd(cmd_read, tab[i], 8'h00);
      check(q, 8'h11 * 8'(i + 1));
    end
  endtask

  task automatic s_refuse();
    @(posedge clock);
    store_cap_ok <= 1'b0;
    do_cmd(cmd_write, 13'h0040, 8'h99);
    check(refused, 1'b1);
    do_cmd(cmd_save, 13'h0000, 8'h00);
    check(refused, 1'b1);
    @(posedge clock);
    store_cap_ok <= 1'b1;
    do_cmd(cmd_read, 13'h0040, 8'h00);
    check(q, 8'h1a);
  endtask

  task automatic s_seq(input logic [7:0] op, input logic [12:0] last);
    logic [12:0] ex [6] = '{13'h0000, 13'h1555, 13'h0aaa, 13'h1fff, 13'h10f0, last};
    seq_q.delete();
    rec = 1'b1;
    do_cmd(op, 13'h0000, 8'h00);
    rec = 1'b0;
    check(16'(seq_q.size()), 16'h0006);
    foreach (ex[i])
      check(seq_q[i], {1'b1, ex[i]});
  endtask

  // saved byte survives a later overwrite through restore
  task automatic s_save_restore();
    do_cmd(cmd_write, 13'h0200, 8'h3c);
    s_seq(cmd_save, 13'h0f0f);
    do_cmd(cmd_write, 13'h0200, 8'hc3);
    s_seq(cmd_restore, 13'h0f0e);
    do_cmd(cmd_read, 13'h0200, 8'h00);
    check(q, 8'h3c);
    do_cmd(cmd_read, 13'h1fff, 8'h00);
    check(q, 8'h22);
  endtask

  task automatic s_brownout();
    do_cmd(cmd_write, 13'h0200, 8'h77);
    @(posedge clock);
    supply_ok <= 1'b0;
    repeat (3) @(posedge clock);
    supply_ok <= 1'b1;
    wait_rsp();
    do_cmd(cmd_read, 13'h0200, 8'h00);
    check(q, 8'h3c);
  endtask

  initial
  begin
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    s_powerup();
    s_rw();
    s_refuse();
    s_save_restore();
    s_brownout();
    end_of_test();
  end

  // whole run needs well under ten thousand cycles
  initial
  begin
    #250000;
    miscompares++;
    end_of_test();
  end
endmodule
`default_nettype wire

// >>> verilog/nvsh_counter.sv
/*
  down counter that times the device's long busy periods.
  assumes a single clock and load pulses from nvsh_host.
*/
`timescale 1ns/1ps
`default_nettype none
module nvsh_counter #(
  parameter int unsigned width = 24
)
(
  input wire logic clock,
  input wire logic rst,
  input wire logic load,
  input wire logic [width-1:0] load_value,
  output logic done
);
  typedef struct packed {
    logic [width-1:0] count;
    logic done;
  } nvsh_cnt_type;
  nvsh_cnt_type state;
  nvsh_cnt_type next_state;

  // done is high once the count has run out
  always_comb
  begin
    next_state = state;
    if (load)
    begin
      next_state.count = load_value;
      next_state.done = 1'b0;
    end
    else if (state.count != '0)
    begin
      next_state.count = state.count - 1'b1;
      next_state.done = (state.count == {{(width-1){1'b0}}, 1'b1});
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state <= '{count: '0, done: 1'b1};
    end
    else
    begin
      state <= next_state;
    end
  end
  assign done = state.done;
endmodule
`default_nettype wire

// >>> verilog/nvsh_host.sv
/*
  host controller for a parallel shadow-backed 8k x 8 static ram: reads, writes,
  and the six-read save and restore sequences, with busy timing after each.
  assumes the device pins are synchronous to clock and the testbench resolves the
  shared data lines from the output enable.
*/
`timescale 1ns/1ps
`default_nettype none
module nvsh_host #(
  parameter int unsigned save_cycles = nvsh_pkg::save_duration_us * nvsh_pkg::clock_mhz,
  parameter int unsigned restore_cycles = nvsh_pkg::restore_duration_us * nvsh_pkg::clock_mhz,
  parameter int unsigned powerup_cycles = nvsh_pkg::powerup_restore_duration_us * nvsh_pkg::clock_mhz
)
(
  input wire logic clock,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_op,
  input wire logic [nvsh_pkg::addr_width-1:0] cmd_addr,
  input wire logic [nvsh_pkg::data_width-1:0] cmd_wdata,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [nvsh_pkg::data_width-1:0] rsp_rdata,
  output logic save_refused,
  input wire logic supply_ok,
  input wire logic store_cap_ok,
  output logic [nvsh_pkg::addr_width-1:0] byte_select_lines,
  output logic [nvsh_pkg::data_width-1:0] shared_data_lines_out,
  output logic shared_data_lines_oe,
  input wire logic [nvsh_pkg::data_width-1:0] shared_data_lines_in,
  output logic chip_select_n,
  output logic write_strobe_n,
  output logic output_drive_n
);
  import nvsh_pkg::*;

  initial
  begin
    if (save_cycles < 2 || restore_cycles < 2 || powerup_cycles < 2 || powerup_cycles >= (1 << 24))
      $error("nvsh_host: busy counts out of range");
  end

  typedef struct packed {
    nvsh_state_type fsm;
    logic [2:0] step;
    logic [3:0] wait_cnt;
    logic is_save;
    logic supply_seen;
    logic powerup_pending;
    logic cmd_ready;
    logic rsp_valid;
    logic [7:0] rsp_rdata;
    logic save_refused;
    logic [12:0] addr;
    logic [7:0] wdata;
    logic oe;
    logic cs_n;
    logic we_n;
    logic od_n;
    logic load;
    logic [23:0] load_value;
  } nvsh_host_type;
  nvsh_host_type state;
  nvsh_host_type next_state;
  logic busy_done;

  // address of each sequence step; the last depends on save or restore
  function automatic logic [12:0] seq_addr(input logic [2:0] step, input logic save);
    case (step)
      3'd0: seq_addr = seq_addr_0;
      3'd1: seq_addr = seq_addr_1;
      3'd2: seq_addr = seq_addr_2;
      3'd3: seq_addr = seq_addr_3;
      3'd4: seq_addr = seq_addr_4;
      default: seq_addr = save ? seq_save_addr : seq_restore_addr;
    endcase
  endfunction

  nvsh_counter #(.width(24)) busy_timer (
    .clock(clock),
    .rst(rst),
    .load(state.load),
    .load_value(state.load_value),
    .done(busy_done)
  );

  // one sequencer for plain accesses, sequences and busy waits
  always_comb
  begin
    next_state = state;
    next_state.rsp_valid = 1'b0;
    next_state.save_refused = 1'b0;
    next_state.load = 1'b0;
    next_state.supply_seen = supply_ok;
    if (!supply_ok)
      next_state.powerup_pending = 1'b1;
    if (state.wait_cnt != 4'd0)
      next_state.wait_cnt = state.wait_cnt - 4'd1;
    case (state.fsm)
      nvsh_idle:
      begin
        if (state.powerup_pending && supply_ok && state.supply_seen)
        begin
          // wait out the automatic restore with all strobes idle
          next_state.powerup_pending = 1'b0;
          next_state.cmd_ready = 1'b0;
          next_state.load = 1'b1;
          next_state.load_value = 24'(powerup_cycles);
          next_state.fsm = nvsh_busy;
        end
        else if (cmd_valid && state.cmd_ready)
        begin
          next_state.cmd_ready = 1'b0;
          next_state.addr = cmd_addr;
          next_state.wdata = cmd_wdata;
          if (cmd_op == cmd_write && store_cap_ok)
          begin
            // data and address settle before the strobe drops
            next_state.oe = 1'b1;
            next_state.od_n = 1'b1;
            next_state.wait_cnt = 4'(setup_cycles);
            next_state.fsm = nvsh_wr_setup;
          end
          else if (cmd_op == cmd_save || cmd_op == cmd_restore)
          begin
            if (cmd_op == cmd_save && !store_cap_ok)
            begin
              next_state.save_refused = 1'b1;
              next_state.cmd_ready = 1'b1;
            end
            else
            begin
              next_state.is_save = (cmd_op == cmd_save);
              next_state.step = 3'd0;
              next_state.addr = seq_addr_0;
              next_state.cs_n = 1'b0;
              next_state.we_n = 1'b1;
              next_state.wait_cnt = 4'(read_cycles);
              next_state.fsm = nvsh_seq_step;
            end
          end
          else if (cmd_op == cmd_write)
          begin
            // write blocked on a weak store capacitor: answer without dropping a strobe or driving data; only the address lines take cmd_addr
            next_state.save_refused = 1'b1;
            next_state.cmd_ready = 1'b1;
          end
          else
          begin
            next_state.cs_n = 1'b0;
            next_state.od_n = 1'b0;
            next_state.wait_cnt = 4'(read_cycles > addr_cycles ? read_cycles : addr_cycles);
            next_state.fsm = nvsh_rd_wait;
          end
        end
      end
      nvsh_rd_wait:
      begin
        if (state.wait_cnt == 4'd0)
        begin
          next_state.rsp_valid = 1'b1;
          next_state.rsp_rdata = shared_data_lines_in;
          next_state.cs_n = 1'b1;
          next_state.od_n = 1'b1;
          next_state.fsm = nvsh_rd_gap;
        end
      end
      nvsh_rd_gap:
      begin
        next_state.cmd_ready = 1'b1;
        next_state.fsm = nvsh_idle;
      end
      nvsh_wr_setup:
      begin
        if (state.wait_cnt == 4'd0)
        begin
          next_state.cs_n = 1'b0;
          next_state.we_n = 1'b0;
          next_state.wait_cnt = 4'(setup_cycles > float_cycles ? setup_cycles : float_cycles);
          next_state.fsm = nvsh_wr_pulse;
        end
      end
      nvsh_wr_pulse:
      begin
        if (state.wait_cnt == 4'd0)
        begin
          // strobes rise with data and address still held
          next_state.cs_n = 1'b1;
          next_state.we_n = 1'b1;
          next_state.fsm = nvsh_wr_end;
        end
      end
      nvsh_wr_end:
      begin
        next_state.oe = 1'b0;
        next_state.rsp_valid = 1'b1;
        next_state.cmd_ready = 1'b1;
        next_state.fsm = nvsh_idle;
      end
      nvsh_seq_step:
      begin
        if (state.wait_cnt == 4'd0)
        begin
          // select-timed read: select rises to close the step
          next_state.cs_n = 1'b1;
          next_state.fsm = nvsh_seq_gap;
        end
      end
      nvsh_seq_gap:
      begin
        if (state.step == 3'd5)
        begin
          next_state.load = 1'b1;
          next_state.load_value = state.is_save ? 24'(save_cycles) : 24'(restore_cycles);
          next_state.fsm = nvsh_busy;
        end
        else
        begin
          // steps go back to back; nothing else is let in between
          next_state.step = state.step + 3'd1;
          next_state.addr = seq_addr(state.step + 3'd1, state.is_save);
          next_state.cs_n = 1'b0;
          next_state.wait_cnt = 4'(read_cycles);
          next_state.fsm = nvsh_seq_step;
        end
      end
      nvsh_busy:
      begin
        // device is erasing, programming or restoring; pins stay idle
        if (busy_done && !state.load)
        begin
          next_state.rsp_valid = 1'b1;
          next_state.cmd_ready = 1'b1;
          next_state.fsm = nvsh_idle;
        end
      end
      default:
        next_state.fsm = nvsh_idle;
    endcase
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state <= '{fsm: nvsh_idle, cs_n: 1'b1, we_n: 1'b1, od_n: 1'b1, powerup_pending: 1'b1,
                 default: '0};
    end
    else
    begin
      state <= next_state;
    end
  end

  assign cmd_ready = state.cmd_ready;
  assign rsp_valid = state.rsp_valid;
  assign rsp_rdata = state.rsp_rdata;
  assign save_refused = state.save_refused;
  assign byte_select_lines = state.addr;
  assign shared_data_lines_out = state.wdata;
  assign shared_data_lines_oe = state.oe;
  assign chip_select_n = state.cs_n;
  assign write_strobe_n = state.we_n;
  assign output_drive_n = state.od_n;

  write_no_drive_a: assert property (@(posedge clock) disable iff (rst)
    !write_strobe_n |-> output_drive_n && shared_data_lines_oe) else $error("drive low during write");
  addr_hold_a: assert property (@(posedge clock) disable iff (rst)
    !write_strobe_n |=> $stable(byte_select_lines) && $stable(shared_data_lines_out))
    else $error("address or data moved during write");
  seq_we_high_a: assert property (@(posedge clock) disable iff (rst)
    state.fsm == nvsh_seq_step |-> write_strobe_n) else $error("write strobe low in sequence");
  seq_first_a: assert property (@(posedge clock) disable iff (rst)
    state.fsm == nvsh_seq_step && state.step == 3'd0 |-> byte_select_lines == 13'h0000)
    else $error("sequence does not open at zero");
  seq_fifth_a: assert property (@(posedge clock) disable iff (rst)
    state.fsm == nvsh_seq_step && state.step == 3'd4 |-> byte_select_lines == 13'h10f0)
    else $error("fifth step address wrong");
  seq_last_a: assert property (@(posedge clock) disable iff (rst)
    state.fsm == nvsh_seq_step && state.step == 3'd5 |->
    byte_select_lines == (state.is_save ? 13'h0f0f : 13'h0f0e)) else $error("last step address wrong");
  busy_idle_a: assert property (@(posedge clock) disable iff (rst)
    state.fsm == nvsh_busy |-> chip_select_n && write_strobe_n && !shared_data_lines_oe)
    else $error("pins active while busy");
  read_strobes_a: assert property (@(posedge clock) disable iff (rst)
    $rose(rsp_valid) && $past(state.fsm) == nvsh_rd_wait |-> $past(!chip_select_n && !output_drive_n, 2))
    else $error("read data taken outside select");
  weak_cap_a: assert property (@(posedge clock) disable iff (rst)
    state.fsm == nvsh_idle && cmd_valid && cmd_ready && !store_cap_ok && (cmd_op == cmd_write || cmd_op == cmd_save)
    && !(state.powerup_pending && supply_ok && state.supply_seen) |=> save_refused)
    else $error("weak capacitor did not refuse");
  seq_steps_a: assert property (@(posedge clock) disable iff (rst)
    state.fsm == nvsh_seq_gap && state.step != 3'd5 |=> state.fsm == nvsh_seq_step && !chip_select_n)
    else $error("sequence gap not followed by step");
endmodule
`default_nettype wire

// >>> verilog/nvsh_pkg.sv
/*
  constants for the host-side controller of a parallel shadow-backed static ram.
  assumes the device sits on the pins driven by nvsh_host, one clock domain at 40 mhz.
*/
// Notes on behaviour
// - host keeps address stable from before write until a strobe rises.
// - byte captured at write end; host holds data a setup time before.
// - host keeps output drive high for the whole write.
// - save/restore needs six select-timed reads: 0x0000, 0x1555, 0x0AAA first.
// - fourth read 0x1FFF, fifth 0x10F0; both return normal data.
// - steps are reads; output drive low is optional during them.
// - host must not hold a write when the power-up restore ends.
// - host keeps write strobe high through all six sequence reads.
package nvsh_pkg;
  localparam int unsigned clock_mhz = 40;
  localparam int unsigned addr_width = 13;
  localparam int unsigned data_width = 8;
  // access timing in ns, arbitrary speed grade
  localparam int unsigned addr_access_delay_ns = 45;
  localparam int unsigned select_access_delay_ns = 45;
  localparam int unsigned outen_access_delay_ns = 20;
  localparam int unsigned data_setup_time_ns = 15;
  localparam int unsigned write_float_delay_ns = 15;
  // least times round up
  localparam int unsigned read_cycles = ((select_access_delay_ns > outen_access_delay_ns ?
    select_access_delay_ns : outen_access_delay_ns) * clock_mhz + 999) / 1000;
  localparam int unsigned addr_cycles = (addr_access_delay_ns * clock_mhz + 999) / 1000;
  localparam int unsigned setup_cycles = (data_setup_time_ns * clock_mhz + 999) / 1000;
  localparam int unsigned float_cycles = (write_float_delay_ns * clock_mhz + 999) / 1000;
  // defaults for long waits, in us; real values are parameters of the top
  localparam int unsigned save_duration_us = 10000;
  localparam int unsigned restore_duration_us = 20;
  localparam int unsigned powerup_restore_duration_us = 20000;
  // the six-step sequence
  localparam logic [12:0] seq_addr_0 = 13'h0000;
  localparam logic [12:0] seq_addr_1 = 13'h1555;
  localparam logic [12:0] seq_addr_2 = 13'h0aaa;
  localparam logic [12:0] seq_addr_3 = 13'h1fff;
  localparam logic [12:0] seq_addr_4 = 13'h10f0;
  localparam logic [12:0] seq_save_addr = 13'h0f0f;
  localparam logic [12:0] seq_restore_addr = 13'h0f0e;
  localparam logic [7:0] cmd_read = 8'h00;
  localparam logic [7:0] cmd_write = 8'h01;
  localparam logic [7:0] cmd_save = 8'h02;
  localparam logic [7:0] cmd_restore = 8'h03;
  typedef enum logic [3:0] {
    nvsh_idle,
    nvsh_rd_wait,
    nvsh_rd_gap,
    nvsh_wr_setup,
    nvsh_wr_pulse,
    nvsh_wr_end,
    nvsh_seq_step,
    nvsh_seq_gap,
    nvsh_busy
  } nvsh_state_type;
endpackage
